/* testbench/hpsc_slot_model.sv */
`timescale 1ns/1ps
module hpsc_slot_model #(
	parameter int NUM_PORTS = 3,
	parameter int SLOW_CYC  = 20
) (
	input  wire logic                 clk_in,
	input  wire logic                 rst_b_in,
	input  wire logic [NUM_PORTS-1:0] pwr_en_in,
	input  wire logic                 inv_pe_in,
	input  wire logic                 inv_pg_in,
	input  wire logic                 slow_in,
	output logic      [NUM_PORTS-1:0] pwr_good_out
);
	////////////////////////////////////////////////////////////////////////
	// Rail ramp: good only after supply has been on for a while
	int cnt [NUM_PORTS];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int k = 0; k < NUM_PORTS; k++)
				cnt[k] <= 0;
		end else begin
			for (int k = 0; k < NUM_PORTS; k++) begin
				if (!(pwr_en_in[k] ^ inv_pe_in))
					cnt[k] <= 0;
				else if (cnt[k] < 1000)
					cnt[k] <= cnt[k] + 1;
			end
		end
	end

	// Supply loss drops good at once, no hold-up
	always_comb begin
		for (int k = 0; k < NUM_PORTS; k++)
			pwr_good_out[k] = (cnt[k] >= (slow_in ? SLOW_CYC : 1)) ^ inv_pg_in;
	end
endmodule

/* testbench/hpsc_top_tb.sv */
`timescale 1ns/1ps
module hpsc_top_tb;
	localparam int NP   = 3;
	localparam int MS   = 4;
	localparam int STEP = 10 * MS;
	logic          clk;
	logic          rst_b;
	logic [11:0]   addr;
	logic [31:0]   wdata;
	logic [31:0]   rdata;
	logic          wr;
	logic          rd;
	logic [NP-1:0] btn, pres, flt, latch, pg, hot;
	logic [NP-1:0] ai, pi, pe, il, drst_b;
	logic [31:0]   cfg_w;
	logic [31:0]   rv, lv, st, cv;
	logic          slow, iv;
	int            error_cnt, num_checks, p, src, d;
	integer        seed;

	hpsc_top #(.NUM_PORTS(NP), .MS_CYCLES(MS)) dut (
		.REF_CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .ATTENTION_BUTTON_IN(btn),
		.PRESENCE_DETECT_IN(pres), .POWER_FAULT_IN(flt),
		.RETENTION_LATCH_SENSOR_IN(latch), .POWER_GOOD_IN(pg),
		.HOT_RESET_IN(hot), .ATTENTION_INDICATOR_OUT(ai),
		.POWER_INDICATOR_OUT(pi), .POWER_ENABLE_OUT(pe),
		.INTERLOCK_DRIVE_OUT(il), .DS_RESET_B_OUT(drst_b));

	hpsc_slot_model #(.NUM_PORTS(NP)) partner (
		.clk_in(clk), .rst_b_in(rst_b), .pwr_en_in(pe),
		.inv_pe_in(cfg_w[6]), .inv_pg_in(cfg_w[8]), .slow_in(slow),
		.pwr_good_out(pg));

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic reg_wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		if (a == hpsc_pkg::CFG_OFF)
			cfg_w = v;
	endtask

	task automatic reg_rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return drst_b[0];
			1: return pe[0];
			default: return il[0];
		endcase
	endfunction

	// Level v must not show before lo cycles and must show by hi
	task automatic expect_at(input int w, input logic v, input int lo,
			input int hi);
		logic early;
		early = 1'b0;
		for (int n = 0; n < hi; n++) begin
			@(posedge clk);
			#1;
			if (n < lo && pick(w) === v)
				early = 1'b1;
			if (n >= lo && pick(w) === v)
				break;
		end
		check({31'h0, early}, 32'h0);
		check({31'h0, pick(w)}, {31'h0, v});
	endtask

	function automatic logic [31:0] mkcfg(input logic [8:0] inv,
			input logic lk, input logic tg, input logic [1:0] s,
			input logic [7:0] dp, input logic [7:0] dr);
		return {dr, dp, s, tg, lk, 1'b1, 2'b00, inv};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Clock, reset, watchdog
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'hb0e965b9;
		error_cnt = 0;
		num_checks = 0;
		cfg_w = 32'h1414_0800;
		{rst_b, wr, rd, addr, wdata, slow} = '0;
		{btn, pres, flt, latch, hot} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);

		// Reset value, write mask, unmapped hole
		reg_rd(hpsc_pkg::CFG_OFF, rv);
		check(rv, 32'h1414_0800);
		reg_wr(hpsc_pkg::CFG_OFF, 32'hFFFF_FFFF);
		reg_rd(hpsc_pkg::CFG_OFF, rv);
		check(rv, 32'hFFFF_F9FF);
		reg_rd(12'h0334, rv);
		check(rv, 32'h0);

		// Random polarity sweep, slots held off
		for (int it = 0; it < 24; it++) begin
			rv = $random(seed);
			lv = $random(seed);
			reg_wr(hpsc_pkg::CFG_OFF, mkcfg(rv[8:0], rv[12], 1'b0, 2'h0,
				8'h02, 8'h02));
			@(posedge clk);
			btn <= lv[2:0];
			pres <= lv[5:3];
			flt <= lv[8:6];
			latch <= lv[11:9];
			for (p = 0; p < NP; p++)
				reg_wr(hpsc_pkg::SLOT_CTL_BASE + 12'(4 * p),
					{29'h0, lv[13], lv[12], 1'b1});
			repeat (6) @(posedge clk);
			for (p = 0; p < NP; p++) begin
				reg_rd(hpsc_pkg::SLOT_STS_BASE + 12'(4 * p), st);
				cv = {26'h0, rv[12] & (latch[p] ^ rv[3]), 1'b0,
					~rv[12] & (latch[p] ^ rv[3]), flt[p] ^ rv[2],
					pres[p] ^ rv[1], btn[p] ^ rv[0]};
				check(st & 32'h3F, cv);
				check({28'h0, il[p], pe[p], pi[p], ai[p]}, {28'h0, rv[7],
					rv[6], lv[13] ^ rv[5], lv[12] ^ rv[4]});
			end
		end

		// Power sequencing per reset source; source 3 with zero delays
		@(posedge clk);
		latch <= '0;
		for (src = 0; src < 4; src++) begin
			iv = 1'($random(seed));
			slow = src[0];
			d = (src == 3) ? 0 : 2;
			reg_wr(hpsc_pkg::CFG_OFF, mkcfg({2'b00, iv, 6'h0}, 1'b0, 1'b0,
				2'(src), 8'(d), 8'(d)));
			reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h0);
			expect_at(1, ~iv, 0, 4);
			expect_at(0, 1'b1, d ? (d - 1) * STEP : 0, d * STEP + 40);
			@(posedge clk);
			hot[0] <= 1'b1;
			repeat (5) @(posedge clk);
			check({31'h0, drst_b[0]}, {31'h0, src != 2});
			hot[0] <= 1'b0;
			repeat (6) @(posedge clk);
			reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h1);
			expect_at(0, 1'b0, 0, 4);
			expect_at(1, iv, d ? (d - 1) * STEP : 0, d * STEP + 20);
		end

		// Latch-open auto power off, then capability cleared
		slow = 1'b0;
		reg_wr(hpsc_pkg::CFG_OFF, mkcfg(9'h0, 1'b0, 1'b0, 2'h0, 8'h0, 8'h0));
		reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h0);
		expect_at(1, 1'b1, 0, 6);
		@(posedge clk);
		latch[0] <= 1'b1;
		expect_at(1, 1'b0, 0, 20);
		@(posedge clk);
		latch[0] <= 1'b0;
		expect_at(1, 1'b1, 0, 20);
		reg_wr(hpsc_pkg::CAP_OFF, 32'h0);
		@(posedge clk);
		latch[0] <= 1'b1;
		repeat (30) @(posedge clk);
		check({31'h0, pe[0]}, 32'h1);
		reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h1);
		latch[0] <= 1'b0;

		// Interlock: pulse mode first, then toggle
		iv = 1'($random(seed));
		reg_wr(hpsc_pkg::CFG_OFF, mkcfg({1'b0, iv, 7'h0}, 1'b0, 1'b0, 2'h0,
			8'h14, 8'h14));
		reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h9);
		expect_at(2, ~iv, 0, 4);
		expect_at(2, iv, 124 * MS - 4, 125 * MS + 8);
		reg_wr(hpsc_pkg::CFG_OFF, mkcfg({1'b0, iv, 7'h0}, 1'b0, 1'b1, 2'h0,
			8'h14, 8'h14));
		reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h9);
		expect_at(2, ~iv, 0, 4);
		repeat (600) @(posedge clk);
		check({31'h0, il[0]}, {31'h0, ~iv});
		reg_wr(hpsc_pkg::SLOT_CTL_BASE, 32'h9);
		expect_at(2, iv, 0, 4);
		tally_and_finish();
	end
endmodule

/* verilog/hpsc_pkg.sv */
// Behaviour
// - Config bit 0 inverts the sensed attention button input on all ports.
// - Config bit 1 inverts the sensed presence detect input on all ports.
// - Config bit 2 inverts the sensed power fault input on all ports.
// - Config bit 3 inverts the sensed retention latch sensor input.
// - Config bit 4 inverts the driven attention indicator output.
// - Config bit 5 inverts the driven power indicator output.
// - Config bit 6 inverts the driven power enable output.
// - Config bit 7 inverts the driven interlock drive output.
// - Config bit 8 inverts the sensed power good input on all ports.
// - Config bit 12 reads latch sensor inputs as interlock state inputs.
// - Bit 13 clear: interlock command pulses interlock drive for 125 ms.
// - Bit 13 set: interlock command flips the interlock drive level.
// - Reset source field: 0 power enable, 1 power good, 2 hot reset.
// - Wait power-to-reset delay times 10 ms after stable power.
// - Wait reset-to-power-off delay times 10 ms before removing power.
package hpsc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ     = 40_000_000;
	localparam int MS_PER_S   = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int STEP_MS    = 10;
	localparam int PULSE_MS   = 125;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [11:0] CFG_OFF       = 12'h0330;
	localparam logic [11:0] SLOT_CTL_BASE = 12'h0400;
	localparam logic [11:0] SLOT_STS_BASE = 12'h0440;
	localparam logic [11:0] CAP_OFF       = 12'h0480;
	localparam logic [31:0] CFG_RESET     = 32'h1414_0800;
	localparam logic [31:0] CFG_WMASK     = 32'hFFFF_F9FF;
	localparam logic        CAP_RESET     = 1'b1;
	localparam int          MAX_PORTS     = 8;

	typedef enum logic [1:0] {
		RST_SRC_PEC  = 2'h0,
		RST_SRC_PGC  = 2'h1,
		RST_SRC_HOT  = 2'h2,
		RST_SRC_RSVD = 2'h3
	} hpsc_rst_src_e;

	typedef enum logic [1:0] {
		ST_OFF  = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN  = 2'h2,
		ST_DOWN = 2'h3
	} hpsc_state_e;

	typedef struct packed {
		logic [7:0]    reset_to_power_off_delay;
		logic [7:0]    power_to_reset_delay;
		hpsc_rst_src_e rst_src;
		logic          tog_sel;
		logic          lock_state;
		logic          auto_off;
		logic [1:0]    rsvd;
		logic          inv_pg;
		logic          inv_lock_out;
		logic          inv_pe;
		logic          inv_pi;
		logic          inv_ai;
		logic          inv_latch;
		logic          inv_fault;
		logic          inv_presence;
		logic          inv_button;
	} hpsc_cfg_s;

	typedef struct packed {
		logic lock_cmd;
		logic pwr_ind;
		logic attn_ind;
		logic pwr_off;
	} hpsc_ctl_s;

endpackage

/* verilog/hpsc_slot.sv */
`timescale 1ns/1ps
module hpsc_slot (
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              ms_tick_in,
	input  wire logic              step_tick_in,
	input  wire hpsc_pkg::hpsc_cfg_s cfg_in,
	input  wire logic              pwr_req_in,
	input  wire logic              auto_off_in,
	input  wire logic              pwr_good_in,
	input  wire logic              hot_rst_in,
	input  wire logic              lock_cmd_in,
	output logic                   pwr_en_out,
	output logic                   reset_out,
	output logic                   lock_drive_out
);

	localparam logic [6:0] PULSE_LAST = 7'(hpsc_pkg::PULSE_MS - 1);

	hpsc_pkg::hpsc_state_e st_q;
	logic [7:0]            cnt_q;
	logic [6:0]            pcnt_q;
	logic                  pulsing_q;
	logic                  want_on;
	logic                  stable;

	// Open latch overrides the software power request
	assign want_on = pwr_req_in & ~auto_off_in;
	assign stable  = (cfg_in.rst_src == hpsc_pkg::RST_SRC_PGC) ?
		pwr_good_in : pwr_en_out;

	////////////////////////////////////////////////////////////////////////
	// Power and reset sequencing
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q  <= hpsc_pkg::ST_OFF;
			cnt_q <= 8'h00;
		end else begin
			case (st_q)
			hpsc_pkg::ST_OFF: begin
				cnt_q <= 8'h00;
				if (want_on)
					st_q <= hpsc_pkg::ST_WAIT;
			end
			hpsc_pkg::ST_WAIT: begin
				if (!want_on)
					st_q <= hpsc_pkg::ST_OFF;
				else if (!stable)
					cnt_q <= 8'h00;
				else if (cnt_q == cfg_in.power_to_reset_delay)
					st_q <= hpsc_pkg::ST_RUN;
				else if (step_tick_in)
					cnt_q <= cnt_q + 8'h01;
			end
			hpsc_pkg::ST_RUN: begin
				if (!want_on) begin
					st_q  <= hpsc_pkg::ST_DOWN;
					cnt_q <= 8'h00;
				end
			end
			hpsc_pkg::ST_DOWN: begin
				// Sequence always completes, even if power is asked again
				if (cnt_q == cfg_in.reset_to_power_off_delay)
					st_q <= hpsc_pkg::ST_OFF;
				else if (step_tick_in)
					cnt_q <= cnt_q + 8'h01;
			end
			default: st_q <= hpsc_pkg::ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pwr_en_out <= 1'b0;
			reset_out  <= 1'b1;
		end else begin
			pwr_en_out <= (st_q != hpsc_pkg::ST_OFF);
			reset_out  <= (st_q != hpsc_pkg::ST_RUN) |
				((cfg_in.rst_src == hpsc_pkg::RST_SRC_HOT) &
				hot_rst_in);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interlock drive
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lock_drive_out <= 1'b0;
			pulsing_q      <= 1'b0;
			pcnt_q         <= 7'h00;
		end else if (lock_cmd_in) begin
			if (cfg_in.tog_sel) begin
				lock_drive_out <= ~lock_drive_out;
				pulsing_q      <= 1'b0;
			end else begin
				lock_drive_out <= 1'b1;
				pulsing_q      <= 1'b1;
				pcnt_q         <= 7'h00;
			end
		end else if (pulsing_q && ms_tick_in) begin
			if (pcnt_q == PULSE_LAST) begin
				lock_drive_out <= 1'b0;
				pulsing_q      <= 1'b0;
			end else begin
				pcnt_q <= pcnt_q + 7'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	chk_run_entry: assert property (
		st_q == hpsc_pkg::ST_WAIT ##1 st_q == hpsc_pkg::ST_RUN
		|-> $past(cnt_q) == $past(cfg_in.power_to_reset_delay) && $past(stable))
		else $error("reset released before power delay");
	chk_off_entry: assert property (
		st_q == hpsc_pkg::ST_DOWN ##1 st_q == hpsc_pkg::ST_OFF
		|-> $past(cnt_q) == $past(cfg_in.reset_to_power_off_delay))
		else $error("power removed before reset delay");
	chk_auto_off: assert property (
		st_q == hpsc_pkg::ST_RUN && auto_off_in
		|=> st_q == hpsc_pkg::ST_DOWN ##1 reset_out)
		else $error("open latch did not start power off");
	chk_toggle_flip: assert property (
		lock_cmd_in && cfg_in.tog_sel
		|=> lock_drive_out != $past(lock_drive_out))
		else $error("interlock toggle did not flip");
	chk_pulse_end: assert property (
		pulsing_q && ms_tick_in && pcnt_q == PULSE_LAST && !lock_cmd_in
		|=> !lock_drive_out && !pulsing_q)
		else $error("interlock pulse did not end");

endmodule

/* verilog/hpsc_top.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module hpsc_top #(
	parameter int NUM_PORTS = 3,
	parameter int MS_CYCLES = hpsc_pkg::CYC_PER_MS
) (
	input  wire logic                 REF_CLK_IN,
	input  wire logic                 RST_B_IN,
	input  wire logic [11:0]          REG_ADDR_IN,
	input  wire logic [31:0]          REG_WDATA_IN,
	input  wire logic                 REG_WR_IN,
	input  wire logic                 REG_RD_IN,
	output logic      [31:0]          REG_RDATA_OUT,
	input  wire logic [NUM_PORTS-1:0] ATTENTION_BUTTON_IN,
	input  wire logic [NUM_PORTS-1:0] PRESENCE_DETECT_IN,
	input  wire logic [NUM_PORTS-1:0] POWER_FAULT_IN,
	input  wire logic [NUM_PORTS-1:0] RETENTION_LATCH_SENSOR_IN,
	input  wire logic [NUM_PORTS-1:0] POWER_GOOD_IN,
	input  wire logic [NUM_PORTS-1:0] HOT_RESET_IN,
	output logic      [NUM_PORTS-1:0] ATTENTION_INDICATOR_OUT,
	output logic      [NUM_PORTS-1:0] POWER_INDICATOR_OUT,
	output logic      [NUM_PORTS-1:0] POWER_ENABLE_OUT,
	output logic      [NUM_PORTS-1:0] INTERLOCK_DRIVE_OUT,
	output logic      [NUM_PORTS-1:0] DS_RESET_B_OUT
);

	generate
		if (NUM_PORTS < 1 || NUM_PORTS > hpsc_pkg::MAX_PORTS ||
			MS_CYCLES < 2)
			$error("hpsc_top: unsupported parameter value");
	endgenerate

	localparam logic [31:0] MS_LAST   = 32'(MS_CYCLES - 1);
	localparam logic [3:0]  STEP_LAST = 4'(hpsc_pkg::STEP_MS - 1);

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_b;

	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_b = rst_sync_q;

	////////////////////////////////////////////////////////////////////////
	// Millisecond and 10 ms ticks
	logic [31:0] ms_cnt_q;
	logic [3:0]  step_cnt_q;
	logic        ms_tick_q;
	logic        step_tick_q;

	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			ms_cnt_q  <= 32'h0000_0000;
			ms_tick_q <= 1'b0;
		end else if (ms_cnt_q == MS_LAST) begin
			ms_cnt_q  <= 32'h0000_0000;
			ms_tick_q <= 1'b1;
		end else begin
			ms_cnt_q  <= ms_cnt_q + 32'h0000_0001;
			ms_tick_q <= 1'b0;
		end
	end

	// Step tick rides on a ms tick so both delays share one time base
	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			step_cnt_q  <= 4'h0;
			step_tick_q <= 1'b0;
		end else begin
			step_tick_q <= 1'b0;
			if (ms_cnt_q == MS_LAST) begin
				if (step_cnt_q == STEP_LAST) begin
					step_cnt_q  <= 4'h0;
					step_tick_q <= 1'b1;
				end else begin
					step_cnt_q <= step_cnt_q + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	hpsc_pkg::hpsc_cfg_s cfg_q;
	hpsc_pkg::hpsc_ctl_s ctl_q [NUM_PORTS];
	logic                cap_q;
	logic [2:0]          idx;
	logic                ctl_hit;
	logic                sts_hit;
	logic                idx_ok;
	logic [NUM_PORTS-1:0] lock_cmd;

	assign idx     = REG_ADDR_IN[4:2];
	assign idx_ok  = (32'(idx) < NUM_PORTS) && (REG_ADDR_IN[1:0] == 2'h0);
	assign ctl_hit = idx_ok &&
		(REG_ADDR_IN[11:5] == hpsc_pkg::SLOT_CTL_BASE[11:5]);
	assign sts_hit = idx_ok &&
		(REG_ADDR_IN[11:5] == hpsc_pkg::SLOT_STS_BASE[11:5]);

	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b)
			cfg_q <= hpsc_pkg::CFG_RESET;
		else if (REG_WR_IN && REG_ADDR_IN == hpsc_pkg::CFG_OFF)
			cfg_q <= REG_WDATA_IN & hpsc_pkg::CFG_WMASK;
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b)
			cap_q <= hpsc_pkg::CAP_RESET;
		else if (REG_WR_IN && REG_ADDR_IN == hpsc_pkg::CAP_OFF)
			cap_q <= REG_WDATA_IN[0];
	end

	// Command bit is a write pulse only and is never stored
	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NUM_PORTS; p++)
				ctl_q[p] <= 4'h1;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (REG_WR_IN && ctl_hit && 32'(idx) == p)
					ctl_q[p] <= {1'b0, REG_WDATA_IN[2:0]};
			end
		end
	end

	always_comb begin
		lock_cmd = '0;
		for (int p = 0; p < NUM_PORTS; p++)
			lock_cmd[p] = REG_WR_IN && ctl_hit && 32'(idx) == p &&
				REG_WDATA_IN[3];
	end

	////////////////////////////////////////////////////////////////////////
	// Pin normalisation: inner logic sees 1 as active
	logic [NUM_PORTS-1:0] btn;
	logic [NUM_PORTS-1:0] present;
	logic [NUM_PORTS-1:0] fault;
	logic [NUM_PORTS-1:0] latch_raw;
	logic [NUM_PORTS-1:0] latch_open;
	logic [NUM_PORTS-1:0] lock_state;
	logic [NUM_PORTS-1:0] pgood;
	logic [NUM_PORTS-1:0] auto_off;

	assign btn       = ATTENTION_BUTTON_IN ^
		{NUM_PORTS{cfg_q.inv_button}};
	assign present   = PRESENCE_DETECT_IN ^
		{NUM_PORTS{cfg_q.inv_presence}};
	assign fault     = POWER_FAULT_IN ^
		{NUM_PORTS{cfg_q.inv_fault}};
	assign latch_raw = RETENTION_LATCH_SENSOR_IN ^
		{NUM_PORTS{cfg_q.inv_latch}};
	assign pgood     = POWER_GOOD_IN ^
		{NUM_PORTS{cfg_q.inv_pg}};

	// Same pins serve either the latch or the lock state, never both
	assign latch_open = cfg_q.lock_state ? '0 : latch_raw;
	assign lock_state = cfg_q.lock_state ? latch_raw : '0;
	assign auto_off   = {NUM_PORTS{cfg_q.auto_off & cap_q}} &
		latch_open;

	////////////////////////////////////////////////////////////////////////
	// Slots
	logic [NUM_PORTS-1:0] pwr_en;
	logic [NUM_PORTS-1:0] slot_rst;
	logic [NUM_PORTS-1:0] lock_drv;

	generate
		for (genvar g = 0; g < NUM_PORTS; g++) begin : g_slot
			hpsc_slot u_slot (
				.clk_in         (REF_CLK_IN),
				.rst_b_in       (rst_b),
				.ms_tick_in     (ms_tick_q),
				.step_tick_in   (step_tick_q),
				.cfg_in         (cfg_q),
				.pwr_req_in     (~ctl_q[g].pwr_off),
				.auto_off_in    (auto_off[g]),
				.pwr_good_in    (pgood[g]),
				.hot_rst_in     (HOT_RESET_IN[g]),
				.lock_cmd_in    (lock_cmd[g]),
				.pwr_en_out     (pwr_en[g]),
				.reset_out      (slot_rst[g]),
				.lock_drive_out (lock_drv[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, inverted on the way out per config bit; downstream reset always inverted
	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b) begin
			ATTENTION_INDICATOR_OUT <= '0;
			POWER_INDICATOR_OUT     <= '0;
			POWER_ENABLE_OUT        <= '0;
			INTERLOCK_DRIVE_OUT     <= '0;
			DS_RESET_B_OUT          <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				ATTENTION_INDICATOR_OUT[p] <= ctl_q[p].attn_ind ^
					cfg_q.inv_ai;
				POWER_INDICATOR_OUT[p]     <= ctl_q[p].pwr_ind ^
					cfg_q.inv_pi;
			end
			POWER_ENABLE_OUT    <= pwr_en ^
				{NUM_PORTS{cfg_q.inv_pe}};
			INTERLOCK_DRIVE_OUT <= lock_drv ^
				{NUM_PORTS{cfg_q.inv_lock_out}};
			DS_RESET_B_OUT      <= ~slot_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (REG_ADDR_IN == hpsc_pkg::CFG_OFF)
			rd_mux = cfg_q;
		else if (REG_ADDR_IN == hpsc_pkg::CAP_OFF)
			rd_mux = {31'h0000_0000, cap_q};
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (32'(idx) == p && ctl_hit)
				rd_mux = {28'h000_0000, 1'b0, ctl_q[p].pwr_ind,
					ctl_q[p].attn_ind, ctl_q[p].pwr_off};
			if (32'(idx) == p && sts_hit)
				rd_mux = {23'h00_0000, lock_drv[p], slot_rst[p],
					pwr_en[p], lock_state[p], pgood[p],
					latch_open[p], fault[p], present[p], btn[p]};
		end
	end

	// Unmapped reads answer zero; data stands one cycle only
	always_ff @(posedge REF_CLK_IN or negedge rst_b) begin
		if (!rst_b)
			REG_RDATA_OUT <= 32'h0000_0000;
		else if (REG_RD_IN)
			REG_RDATA_OUT <= rd_mux;
		else
			REG_RDATA_OUT <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!rst_b);

	sequence s_step_due;
		ms_cnt_q == MS_LAST && step_cnt_q == STEP_LAST;
	endsequence

	chk_step_tick: assert property (
		s_step_due |=> step_tick_q && ms_tick_q ##1 !step_tick_q)
		else $error("10 ms tick not produced");
	chk_pe_polarity: assert property (
		POWER_ENABLE_OUT ==
		($past(pwr_en) ^ {NUM_PORTS{$past(cfg_q.inv_pe)}}))
		else $error("power enable polarity wrong");
	chk_lock_polarity: assert property (
		INTERLOCK_DRIVE_OUT ==
		($past(lock_drv) ^ {NUM_PORTS{$past(cfg_q.inv_lock_out)}}))
		else $error("interlock polarity wrong");
	chk_cfg_reserved: assert property (
		REG_RD_IN && REG_ADDR_IN == hpsc_pkg::CFG_OFF
		|=> REG_RDATA_OUT[10:9] == 2'h0 &&
		REG_RDATA_OUT[15:14] == $past(cfg_q.rst_src))
		else $error("config readback wrong");
	chk_latch_mode: assert property (
		cfg_q.lock_state |-> auto_off == '0 && latch_open == '0)
		else $error("lock state mode still acts on latch");
	chk_rdata_idle: assert property (
		!REG_RD_IN |=> REG_RDATA_OUT == 32'h0000_0000)
		else $error("read data held beyond one cycle");

	////////////////////////////////////////////////////////////////////////
	// Status readback of port 0 against the raw pins
	sequence s_sts0_read;
		REG_RD_IN && sts_hit && idx == 3'h0;
	endsequence

	chk_sts_button: assert property (
		s_sts0_read |=> REG_RDATA_OUT[0] ==
		($past(ATTENTION_BUTTON_IN[0]) ^ $past(cfg_q.inv_button)))
		else $error("button sense wrong");

	chk_sts_presence: assert property (
		s_sts0_read |=> REG_RDATA_OUT[1] ==
		($past(PRESENCE_DETECT_IN[0]) ^ $past(cfg_q.inv_presence)))
		else $error("presence sense wrong");

	chk_sts_fault: assert property (
		s_sts0_read |=> REG_RDATA_OUT[2] ==
		($past(POWER_FAULT_IN[0]) ^ $past(cfg_q.inv_fault)))
		else $error("fault sense wrong");

	chk_sts_latch: assert property (
		s_sts0_read |=> REG_RDATA_OUT[3] ==
		($past(RETENTION_LATCH_SENSOR_IN[0] ^ cfg_q.inv_latch) &
		~$past(cfg_q.lock_state)))
		else $error("latch sense wrong");

	chk_sts_pgood: assert property (
		s_sts0_read |=> REG_RDATA_OUT[4] ==
		($past(POWER_GOOD_IN[0]) ^ $past(cfg_q.inv_pg)))
		else $error("power good sense wrong");

	chk_ai_polarity: assert property (
		ATTENTION_INDICATOR_OUT[0] ==
		($past(ctl_q[0].attn_ind) ^ $past(cfg_q.inv_ai)))
		else $error("attention indicator polarity wrong");

	chk_pi_polarity: assert property (
		POWER_INDICATOR_OUT[0] ==
		($past(ctl_q[0].pwr_ind) ^ $past(cfg_q.inv_pi)))
		else $error("power indicator polarity wrong");

	// Without the capability an open latch must never cut power
	chk_cap_gate: assert property (
		!(cfg_q.auto_off && cap_q) |-> auto_off == '0)
		else $error("auto power off without capability");

	chk_ms_tick: assert property (
		ms_cnt_q == MS_LAST |=> ms_tick_q ##1 !ms_tick_q)
		else $error("1 ms tick not produced");

	chk_lock_cmd: assert property (
		lock_cmd != '0 |-> REG_WR_IN && ctl_hit && REG_WDATA_IN[3])
		else $error("interlock command without write");

	chk_cfg_write: assert property (
		REG_WR_IN && REG_ADDR_IN == hpsc_pkg::CFG_OFF
		|=> 32'(cfg_q) == $past(REG_WDATA_IN & hpsc_pkg::CFG_WMASK))
		else $error("config write not taken");

	chk_ds_reset: assert property (
		DS_RESET_B_OUT == ~$past(slot_rst))
		else $error("downstream reset pin wrong");

endmodule

/* verilog/hpsc_top_unused.sv */
`timescale 1ns/1ps
